// [rtl/cell_protect_config_regs.sv]
// cell protection configuration and command registers with alarm delay timing
`timescale 1ns/10ps
`default_nettype none

module cell_protect_config_regs
    import cell_protect_pkg::*;
#(
    parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire reg_req_s req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    input wire logic continuous_conversion_select_i,
    input wire logic conversion_done_i,
    input wire logic slow_current_latch_done_i,
    input wire logic fast_current_latch_done_i,
    input wire logic voltage_latch_done_i,
    input wire logic ov_condition_i,
    input wire logic uv_condition_i,
    output thresholds_s thresholds_o,
    output levels_s levels_o,
    output logic balance_enable_o,
    output logic ov_detect_enable_o,
    output logic uv_detect_enable_o,
    output logic conversion_start_o,
    output logic slow_current_latch_o,
    output logic fast_current_latch_o,
    output logic voltage_latch_o,
    output logic ov_alarm_o,
    output logic uv_alarm_o
);

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [15:0] hys_mv(input logic [2:0] code);
        hys_mv = 16'((int'(code) + 1) * HYS_STEP_MV);
    endfunction

    function automatic logic [12:0] delay_ms(input logic [2:0] code);
        case (code)
            3'h0: delay_ms = 13'(DLY_MS_0);
            3'h1: delay_ms = 13'(DLY_MS_1);
            3'h2: delay_ms = 13'(DLY_MS_2);
            3'h3: delay_ms = 13'(DLY_MS_3);
            3'h4: delay_ms = 13'(DLY_MS_4);
            3'h5: delay_ms = 13'(DLY_MS_5);
            3'h6: delay_ms = 13'(DLY_MS_6);
            default: delay_ms = 13'(DLY_MS_7);
        endcase
    endfunction

    // delay in clock cycles; 6000 ms at the default rate still fits 32 bits
    function automatic logic [31:0] delay_cycles(input logic [2:0] code);
        delay_cycles = 32'(int'(delay_ms(code)) * CYCLES_PER_MS_P);
    endfunction

    // true once the count has run the whole delay; the limit is never zero
    function automatic logic delay_expired(input logic [31:0] cnt, input logic [31:0] limit);
        delay_expired = cnt >= limit - 32'h1;
    endfunction

    // any drop of the condition restarts the count
    function automatic logic [31:0] next_count(
        input logic active,
        input logic [31:0] cnt,
        input logic [31:0] limit
    );
        if (!active) begin
            next_count = '0;
        end else if (delay_expired(cnt, limit)) begin
            next_count = cnt;
        end else begin
            next_count = cnt + 32'h1;
        end
    endfunction

    // alarm rises at the end of the delay and falls with the condition
    function automatic logic next_alarm(
        input logic active,
        input logic alarm,
        input logic [31:0] cnt,
        input logic [31:0] limit
    );
        if (!active) begin
            next_alarm = 1'b0;
        end else if (delay_expired(cnt, limit)) begin
            next_alarm = 1'b1;
        end else begin
            next_alarm = alarm;
        end
    endfunction

    // one-hot register select; unmapped addresses select nothing
    function automatic logic [2:0] reg_hit(input logic [6:0] addr);
        if (addr == CELL_THRESHOLD_CONTROL_ADDR) begin
            reg_hit = 3'h1;
        end else if (addr == HYSTERESIS_DELAY_CONTROL_ADDR) begin
            reg_hit = 3'h2;
        end else if (addr == OPERATION_COMMAND_ADDR) begin
            reg_hit = 3'h4;
        end else begin
            reg_hit = 3'h0;
        end
    endfunction

    // ************************************************************
    // register file
    // ************************************************************
    logic [15:0] thr_q;
    logic [15:0] thr_d;
    logic [15:0] hys_q;
    logic [15:0] hys_d;
    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic conv_q;
    logic conv_d;
    logic [2:0] hit;

    // reads and writes share one decode of the request address
    assign hit = reg_hit(req_i.addr);

    always_comb begin
        thr_d = thr_q;
        hys_d = hys_q;
        cmd_d = cmd_q;
        conv_d = conv_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        // completion from the converters; a new write one below wins
        if (conv_q && conversion_done_i) begin
            cmd_d[TRIGGER_BIT] = 1'b0;
        end
        if (slow_current_latch_done_i) begin
            cmd_d[SLOW_LATCH_BIT] = 1'b0;
        end
        if (fast_current_latch_done_i) begin
            cmd_d[FAST_LATCH_BIT] = 1'b0;
        end
        if (voltage_latch_done_i) begin
            cmd_d[VOLT_LATCH_BIT] = 1'b0;
        end
        conv_d = conv_q && !conversion_done_i;
        if (req_i.write) begin
            if (hit[0]) begin
                thr_d = req_i.wdata & CELL_THRESHOLD_MASK;
            end else if (hit[1]) begin
                hys_d = req_i.wdata & HYS_DELAY_MASK;
            end else if (hit[2]) begin
                cmd_d[BALANCE_BIT] = req_i.wdata[BALANCE_BIT];
                cmd_d[UV_MASK_BIT] = req_i.wdata[UV_MASK_BIT];
                cmd_d[OV_MASK_BIT] = req_i.wdata[OV_MASK_BIT];
                // is relied on: no start while continuous mode runs
                if (req_i.wdata[TRIGGER_BIT] && !continuous_conversion_select_i) begin
                    cmd_d[TRIGGER_BIT] = 1'b1;
                    conv_d = 1'b1;
                end
                // writing zero leaves a pending latch request alone
                if (req_i.wdata[SLOW_LATCH_BIT]) begin
                    cmd_d[SLOW_LATCH_BIT] = 1'b1;
                end
                if (req_i.wdata[FAST_LATCH_BIT]) begin
                    cmd_d[FAST_LATCH_BIT] = 1'b1;
                end
                if (req_i.wdata[VOLT_LATCH_BIT]) begin
                    cmd_d[VOLT_LATCH_BIT] = 1'b1;
                end
            end
        end
        if (req_i.read) begin
            rvalid_d = 1'b1;
            if (hit[0]) begin
                rdata_d = thr_q;
            end else if (hit[1]) begin
                rdata_d = hys_q;
            end else if (hit[2]) begin
                rdata_d = cmd_q & OP_CMD_MASK;
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            thr_q <= CELL_THRESHOLD_RESET;
            hys_q <= HYS_DELAY_RESET;
            cmd_q <= OP_CMD_RESET;
            conv_q <= 1'b0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else if (en_i) begin
            thr_q <= thr_d;
            hys_q <= hys_d;
            cmd_q <= cmd_d;
            conv_q <= conv_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ************************************************************
    // decoded levels
    // ************************************************************
    thresholds_s thr_fields;
    levels_s levels_d;
    levels_s levels_q;

    assign thr_fields = thr_q[13:0];

    always_comb begin
        levels_d = '0;
        if (thr_fields.overvoltage_threshold >= OV_CODE_MAX) begin
            levels_d.overvoltage_mv = 16'(OV_MV_AT_MAX);
        end else begin
            levels_d.overvoltage_mv = 16'(OV_MV_AT_MAX - VOLT_STEP_MV
                * (int'(OV_CODE_MAX) - int'(thr_fields.overvoltage_threshold)));
        end
        levels_d.undervoltage_mv = 16'(UV_MV_AT_ZERO
            + VOLT_STEP_MV * int'(thr_fields.undervoltage_threshold));
        levels_d.ov_hysteresis_mv = hys_mv(hys_q[OVERVOLTAGE_HYSTERESIS_LSB +: 3]);
        levels_d.uv_hysteresis_mv = hys_mv(hys_q[UNDERVOLTAGE_HYSTERESIS_LSB +: 3]);
        case (thr_fields.fuse_current_threshold_select)
            2'h0: levels_d.fuse_current_uv = FUSE_CUR_UV_CODE0;
            2'h1: levels_d.fuse_current_uv = FUSE_CUR_UV_CODE1;
            2'h2: levels_d.fuse_current_uv = FUSE_CUR_UV_CODE2;
            default: levels_d.fuse_current_uv = FUSE_CUR_UV_CODE3;
        endcase
    end

    // decoded levels are registered so every output but the inverted detect enables leaves a flip-flop
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            levels_q <= '0;
        end else if (en_i) begin
            levels_q <= levels_d;
        end
    end

    // ************************************************************
    // alarm delay timers
    // ************************************************************
    // counters are wide enough for 6000 ms at 100 MHz
    logic [31:0] ov_cnt_q;
    logic [31:0] ov_cnt_d;
    logic [31:0] uv_cnt_q;
    logic [31:0] uv_cnt_d;
    logic ov_alarm_q;
    logic ov_alarm_d;
    logic uv_alarm_q;
    logic uv_alarm_d;
    logic [31:0] ov_limit;
    logic [31:0] uv_limit;
    logic ov_active;
    logic uv_active;

    // a mask bit gates the raw condition, so masking also restarts the count
    assign ov_active = ov_condition_i && !cmd_q[OV_MASK_BIT];
    assign uv_active = uv_condition_i && !cmd_q[UV_MASK_BIT];
    assign ov_limit = delay_cycles(hys_q[OVERVOLTAGE_ALARM_DELAY_LSB +: 3]);
    assign uv_limit = delay_cycles(hys_q[UNDERVOLTAGE_ALARM_DELAY_LSB +: 3]);

    // over-voltage timer
    always_comb begin
        ov_cnt_d = next_count(ov_active, ov_cnt_q, ov_limit);
        ov_alarm_d = next_alarm(ov_active, ov_alarm_q, ov_cnt_q, ov_limit);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ov_cnt_q <= '0;
            ov_alarm_q <= 1'b0;
        end else if (en_i) begin
            ov_cnt_q <= ov_cnt_d;
            ov_alarm_q <= ov_alarm_d;
        end
    end

    // under-voltage timer
    always_comb begin
        uv_cnt_d = next_count(uv_active, uv_cnt_q, uv_limit);
        uv_alarm_d = next_alarm(uv_active, uv_alarm_q, uv_cnt_q, uv_limit);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_cnt_q <= '0;
            uv_alarm_q <= 1'b0;
        end else if (en_i) begin
            uv_cnt_q <= uv_cnt_d;
            uv_alarm_q <= uv_alarm_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign thresholds_o = thr_q[13:0];
    assign levels_o = levels_q;
    assign balance_enable_o = cmd_q[BALANCE_BIT];
    // detect enables read as the inverse of the mask bits
    assign ov_detect_enable_o = !cmd_q[OV_MASK_BIT];
    assign uv_detect_enable_o = !cmd_q[UV_MASK_BIT];
    assign conversion_start_o = conv_q;
    assign slow_current_latch_o = cmd_q[SLOW_LATCH_BIT];
    assign fast_current_latch_o = cmd_q[FAST_LATCH_BIT];
    assign voltage_latch_o = cmd_q[VOLT_LATCH_BIT];
    assign ov_alarm_o = ov_alarm_q;
    assign uv_alarm_o = uv_alarm_q;

endmodule

`default_nettype wire

// [rtl/cell_protect_pkg.sv]
// package: register map, field layout, reset values and timing of the cell protection registers
package cell_protect_pkg;

    localparam logic [6:0] CELL_THRESHOLD_CONTROL_ADDR = 7'h0a;
    localparam logic [6:0] HYSTERESIS_DELAY_CONTROL_ADDR = 7'h0b;
    localparam logic [6:0] OPERATION_COMMAND_ADDR = 7'h0c;

    // cell_threshold_control layout
    localparam int FUSE_CUR_LSB = 12;
    localparam int OV_TH_LSB = 6;
    localparam int UV_TH_LSB = 0;
    localparam logic [15:0] CELL_THRESHOLD_RESET = 16'h0d00;
    localparam logic [15:0] CELL_THRESHOLD_MASK = 16'h3fff;

    // hysteresis_delay_control layout
    localparam int OVERVOLTAGE_HYSTERESIS_LSB = 12;
    localparam int UNDERVOLTAGE_HYSTERESIS_LSB = 8;
    localparam int OVERVOLTAGE_ALARM_DELAY_LSB = 4;
    localparam int UNDERVOLTAGE_ALARM_DELAY_LSB = 0;
    localparam logic [15:0] HYS_DELAY_RESET = 16'h3333;
    localparam logic [15:0] HYS_DELAY_MASK = 16'h7777;

    // operation_command layout
    localparam int BALANCE_BIT = 8;
    localparam int UV_MASK_BIT = 7;
    localparam int OV_MASK_BIT = 6;
    localparam int TRIGGER_BIT = 4;
    localparam int SLOW_LATCH_BIT = 2;
    localparam int FAST_LATCH_BIT = 1;
    localparam int VOLT_LATCH_BIT = 0;
    localparam logic [15:0] OP_CMD_RESET = 16'h0000;
    localparam logic [15:0] OP_CMD_MASK = 16'h01d7;

    // voltage fields, millivolts
    localparam logic [5:0] OV_CODE_MAX = 6'h34;
    localparam int OV_MV_AT_MAX = 4500;
    localparam int UV_MV_AT_ZERO = 500;
    localparam int VOLT_STEP_MV = 50;
    localparam int HYS_STEP_MV = 25;

    // fuse-cut current thresholds, microvolts
    localparam logic [15:0] FUSE_CUR_UV_CODE0 = 16'd1000;
    localparam logic [15:0] FUSE_CUR_UV_CODE1 = 16'd600;
    localparam logic [15:0] FUSE_CUR_UV_CODE2 = 16'd300;
    localparam logic [15:0] FUSE_CUR_UV_CODE3 = 16'd100;

    // alarm delay table, milliseconds
    localparam int DLY_MS_0 = 200;
    localparam int DLY_MS_1 = 400;
    localparam int DLY_MS_2 = 600;
    localparam int DLY_MS_3 = 800;
    localparam int DLY_MS_4 = 1500;
    localparam int DLY_MS_5 = 3000;
    localparam int DLY_MS_6 = 4500;
    localparam int DLY_MS_7 = 6000;
    localparam int CLK_MHZ = 100;
    localparam int CYCLES_PER_MS = CLK_MHZ * 1000;

    typedef struct packed {
        logic [1:0] fuse_current_threshold_select;
        logic [5:0] overvoltage_threshold;
        logic [5:0] undervoltage_threshold;
    } thresholds_s;

    typedef struct packed {
        logic [15:0] overvoltage_mv;
        logic [15:0] undervoltage_mv;
        logic [15:0] ov_hysteresis_mv;
        logic [15:0] uv_hysteresis_mv;
        logic [15:0] fuse_current_uv;
    } levels_s;

    typedef struct packed {
        logic write;
        logic read;
        logic [6:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

endpackage

// [tb/cell_protect_config_regs_asserts.sv]
// port assertions for the cell protection registers
`timescale 1ns/10ps
`default_nettype none
module cell_protect_config_regs_asserts
    import cell_protect_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire reg_req_s req_i,
    input wire logic [15:0] rdata_o,
    input wire logic continuous_conversion_select_i,
    input wire logic voltage_latch_done_i,
    input wire logic ov_condition_i,
    input wire logic uv_condition_i,
    input wire logic balance_enable_o,
    input wire logic ov_detect_enable_o,
    input wire logic uv_detect_enable_o,
    input wire logic conversion_start_o,
    input wire logic voltage_latch_o,
    input wire logic ov_alarm_o,
    input wire logic uv_alarm_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_op;
    assign wr_op = en_i && req_i.write && req_i.addr == OPERATION_COMMAND_ADDR;
    a_op_reserved_zero: assert property (
        en_i && req_i.read && req_i.addr == OPERATION_COMMAND_ADDR
        |=> (rdata_o & ~OP_CMD_MASK) == 16'h0000) else $error("reserved bit read high");
    a_balance_follows: assert property (
        wr_op |=> balance_enable_o == $past(req_i.wdata[BALANCE_BIT]))
        else $error("balance enable wrong");
    a_uv_mask_write: assert property (
        wr_op |=> uv_detect_enable_o != $past(req_i.wdata[UV_MASK_BIT]))
        else $error("uv detect enable wrong");
    a_ov_mask_write: assert property (
        wr_op |=> ov_detect_enable_o != $past(req_i.wdata[OV_MASK_BIT]))
        else $error("ov detect enable wrong");
    a_trigger_starts: assert property (
        wr_op && req_i.wdata[TRIGGER_BIT] && !continuous_conversion_select_i
        |=> conversion_start_o) else $error("manual trigger did not start");
    a_trigger_blocked: assert property (
        wr_op && req_i.wdata[TRIGGER_BIT] && continuous_conversion_select_i
        && !conversion_start_o |=> !conversion_start_o) else $error("trigger not blocked");
    a_volt_latch_clears: assert property (
        en_i && voltage_latch_o && voltage_latch_done_i && !wr_op |=> !voltage_latch_o)
        else $error("voltage latch bit stuck");
    a_ov_alarm_drop: assert property (
        en_i && !ov_condition_i |=> !ov_alarm_o) else $error("ov alarm without condition");
    a_uv_alarm_drop: assert property (
        en_i && !uv_condition_i |=> !uv_alarm_o) else $error("uv alarm without condition");
    a_uv_alarm_masked: assert property (
        !uv_detect_enable_o [*2] |-> !uv_alarm_o) else $error("masked uv alarm raised");
endmodule
`default_nettype wire

// [tb/cell_protect_config_regs_bench.sv]
// self-checking bench for the cell protection registers
`timescale 1ns/10ps
`default_nettype none
module cell_protect_config_regs_bench;
    import cell_protect_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic en_i = 1'b1;
    reg_req_s req_i = '0;
    logic continuous_conversion_select_i = 1'b0;
    logic ov_condition_i = 1'b0;
    logic uv_condition_i = 1'b0;
    logic [15:0] rdata_o;
    logic rvalid_o, balance_enable_o, ov_detect_enable_o, uv_detect_enable_o;
    logic conversion_start_o, slow_current_latch_o, fast_current_latch_o, voltage_latch_o;
    logic ov_alarm_o, uv_alarm_o;
    levels_s levels_o;
    thresholds_s thresholds_o;
    logic [3:0] dn;
    wire logic [3:0] busy;
    int fails = 0;
    int num_checks = 0;
    logic [15:0] fuse_tab [4] = '{16'd1000, 16'd600, 16'd300, 16'd100};
    assign busy = {conversion_start_o, slow_current_latch_o, fast_current_latch_o,
        voltage_latch_o};
    always #5 clk_i = ~clk_i;
    cell_protect_config_regs #(.CYCLES_PER_MS_P(10)) DUT (.clk_i, .rst_i, .en_i, .req_i,
        .rdata_o, .rvalid_o, .continuous_conversion_select_i, .conversion_done_i(dn[3]),
        .slow_current_latch_done_i(dn[2]), .fast_current_latch_done_i(dn[1]),
        .voltage_latch_done_i(dn[0]), .ov_condition_i, .uv_condition_i, .thresholds_o,
        .levels_o, .balance_enable_o, .ov_detect_enable_o, .uv_detect_enable_o,
        .conversion_start_o, .slow_current_latch_o, .fast_current_latch_o,
        .voltage_latch_o, .ov_alarm_o, .uv_alarm_o);
    conv_model conv (.clk_i, .busy_i(busy), .done_o(dn));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        cyc(1);
        req_i = '{1'b1, 1'b0, a, d};
        cyc(1);
        req_i = '0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        cyc(1);
        req_i = '{1'b0, 1'b1, a, 16'h0000};
        cyc(1);
        req_i = '0;
        chk({15'h0000, rvalid_o}, 16'h0001);
        chk(rdata_o, exp);
    endtask
    task automatic lv(input logic [15:0] ov, uv, oh, uh, fc);
        cyc(2);
        chk(levels_o.overvoltage_mv, ov);
        chk(levels_o.undervoltage_mv, uv);
        chk(levels_o.ov_hysteresis_mv, oh);
        chk(levels_o.uv_hysteresis_mv, uh);
        chk(levels_o.fuse_current_uv, fc);
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        cyc(3);
        rst_i = 1'b0;
        rd(CELL_THRESHOLD_CONTROL_ADDR, 16'h0d00);
        rd(HYSTERESIS_DELAY_CONTROL_ADDR, 16'h3333);
        rd(OPERATION_COMMAND_ADDR, 16'h0000);
        chk({13'h0, balance_enable_o, ov_detect_enable_o, uv_detect_enable_o}, 16'h0003);
        lv(16'd4500, 16'd500, 16'd100, 16'd100, 16'd1000);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(CELL_THRESHOLD_CONTROL_ADDR, {2'h0, i[1:0], 6'h20, 6'h32});
            lv(16'd3500, 16'd3000, 16'd100, 16'd100, fuse_tab[i]);
        end
        wr(CELL_THRESHOLD_CONTROL_ADDR, 16'hffc0);
        chk({2'h0, thresholds_o}, 16'h3fc0);
        rd(CELL_THRESHOLD_CONTROL_ADDR, 16'h3fc0);
        lv(16'd4500, 16'd500, 16'd100, 16'd100, 16'd100);
        wr(CELL_THRESHOLD_CONTROL_ADDR, 16'h0080);
        for (int c = 0; c < 8; c++) begin
            wr(HYSTERESIS_DELAY_CONTROL_ADDR, {1'b1, c[2:0], 1'b1, c[2:0], 8'hff});
            rd(HYSTERESIS_DELAY_CONTROL_ADDR, {1'b0, c[2:0], 1'b0, c[2:0], 8'h77});
            lv(16'd2000, 16'd500, 16'(25 * (c + 1)), 16'(25 * (c + 1)), 16'd1000);
        end
        en_i = 1'b0;
        wr(CELL_THRESHOLD_CONTROL_ADDR, 16'h3fff);
        en_i = 1'b1;
        rd(CELL_THRESHOLD_CONTROL_ADDR, 16'h0080);
        $display("thresholds done");
        wr(OPERATION_COMMAND_ADDR, 16'hffe8);
        rd(OPERATION_COMMAND_ADDR, 16'h01c0);
        chk({13'h0, balance_enable_o, ov_detect_enable_o, uv_detect_enable_o}, 16'h0004);
        continuous_conversion_select_i = 1'b1;
        wr(OPERATION_COMMAND_ADDR, 16'h0017);
        chk({12'h0, busy}, 16'h0007);
        rd(OPERATION_COMMAND_ADDR, 16'h0007);
        cyc(20);
        rd(OPERATION_COMMAND_ADDR, 16'h0000);
        continuous_conversion_select_i = 1'b0;
        wr(OPERATION_COMMAND_ADDR, 16'h0010);
        chk({12'h0, busy}, 16'h0008);
        rd(OPERATION_COMMAND_ADDR, 16'h0010);
        cyc(20);
        rd(OPERATION_COMMAND_ADDR, 16'h0000);
        rd(7'h0d, 16'h0000);
        $display("commands done");
        wr(HYSTERESIS_DELAY_CONTROL_ADDR, 16'h3303);
        ov_condition_i = 1'b1;
        cyc(1500);
        ov_condition_i = 1'b0;
        cyc(2);
        chk({15'h0, ov_alarm_o}, 16'h0000);
        ov_condition_i = 1'b1;
        cyc(1990);
        chk({15'h0, ov_alarm_o}, 16'h0000);
        cyc(20);
        chk({15'h0, ov_alarm_o}, 16'h0001);
        ov_condition_i = 1'b0;
        cyc(2);
        chk({15'h0, ov_alarm_o}, 16'h0000);
        uv_condition_i = 1'b1;
        cyc(7990);
        chk({15'h0, uv_alarm_o}, 16'h0000);
        cyc(20);
        chk({15'h0, uv_alarm_o}, 16'h0001);
        wr(OPERATION_COMMAND_ADDR, 16'h0080);
        cyc(2);
        chk({15'h0, uv_alarm_o}, 16'h0000);
        uv_condition_i = 1'b0;
        $display("alarms done");
        report_and_stop();
    end
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end
endmodule
bind cell_protect_config_regs cell_protect_config_regs_asserts chk_u (.clk_i, .rst_i,
    .en_i, .req_i, .rdata_o, .continuous_conversion_select_i, .voltage_latch_done_i,
    .ov_condition_i, .uv_condition_i, .balance_enable_o, .ov_detect_enable_o,
    .uv_detect_enable_o, .conversion_start_o, .voltage_latch_o, .ov_alarm_o, .uv_alarm_o);
`default_nettype wire

// [tb/conv_model.sv]
// converter side model: answers each start or latch request with a done pulse
`timescale 1ns/10ps
`default_nettype none
module conv_model #(
    parameter int LAT = 8
) (
    input wire logic clk_i,
    input wire logic [3:0] busy_i,
    output logic [3:0] done_o = 4'h0
);
    int cnt [4] = '{default: 0};
    // done only while a request stands, so no stale pulse clears a later one
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            done_o[i] <= busy_i[i] && cnt[i] == LAT;
            cnt[i] <= (busy_i[i] && cnt[i] < LAT) ? cnt[i] + 1 : 0;
        end
    end
endmodule
`default_nettype wire
